// file: include/asq_pkg.sv
/*
 Package for the analog scan acquisition controller: modes, link kinds,
 states, pacing figures and the burst memory depth.
 Assumes a 10 MHz system clock; pacing counts are derived from it here.
*/
// ======================================================================
// Behaviour
// - The controller offers single conversions on command, paced continuous scans and bursts.
// - A command-paced request starts one conversion and its value is returned before the next.
// - A paced scan walks a channel list of one to eight channels.
// - A paced scan keeps converting until the host stops it.
// - On the wireless link the aggregate rate of a paced scan is at most 1024 S/s, shared over the channels.
// - On the USB link the aggregate rate of a paced scan is at most 47 kS/s, shared equally.
// - A paced scan over USB delivers its samples in blocks of 32.
// - A paced scan starts on a host command or on an external trigger edge.
// - A burst acquires at up to 47 kS/s even on the wireless link, buffering locally.
// - A burst holds at most 12,288 samples and sends them after acquisition ends.
// - A burst request above 12,288 samples raises an error instead of overflowing.
package asq_pkg;

   // ===================================================================
   // Modes and link kinds
   localparam logic [1:0] ASQ_MODE_SINGLE = 2'h0;
   localparam logic [1:0] ASQ_MODE_PACED  = 2'h1;
   localparam logic [1:0] ASQ_MODE_BURST  = 2'h2;
   localparam logic       ASQ_LINK_WIRE  = 1'b0;
   localparam logic       ASQ_LINK_USB   = 1'b1;

   // ===================================================================
   // Timing
   localparam int unsigned ASQ_CLK_HZ       = 10_000_000;
   localparam int unsigned ASQ_WIRE_RATE_SPS = 1024;
   localparam int unsigned ASQ_USB_RATE_SPS  = 47_000;
   // Least spacing between conversions, rounded up to whole cycles
   localparam int unsigned ASQ_WIRE_CYC =
      (ASQ_CLK_HZ + ASQ_WIRE_RATE_SPS - 1) / ASQ_WIRE_RATE_SPS;
   localparam int unsigned ASQ_USB_CYC =
      (ASQ_CLK_HZ + ASQ_USB_RATE_SPS - 1) / ASQ_USB_RATE_SPS;

   // ===================================================================
   // Sizes
   localparam int unsigned ASQ_MAX_CH     = 8;
   localparam int unsigned ASQ_BLOCK_LEN  = 32;
   localparam int unsigned ASQ_BURST_DEPTH = 12_288;
   localparam int unsigned ASQ_DATA_W     = 12;

   // ===================================================================
   // Sequencer states
   typedef enum logic [5:0] {
      ASQ_IDLE  = 6'b00_0001,
      ASQ_SCONV = 6'b00_0010,
      ASQ_SRET  = 6'b00_0100,
      ASQ_SCAN  = 6'b00_1000,
      ASQ_BACQ  = 6'b01_0000,
      ASQ_BXFER = 6'b10_0000
   } asq_state_t;

endpackage : asq_pkg

// file: include/asq_conv_if.sv
/*
 Carrier between the sequencer and its pacing timer.
 Assumes both ends sit on clk_sys.
*/
`timescale 1ns/1ps
interface asq_conv_if;
   logic        run;
   logic [23:0] period;
   logic        tick;
   modport seq   (output run, output period, input tick);
   modport pacer (input run, input period, output tick);
endinterface : asq_conv_if

// file: rtl/asq_pacer.sv
/*
 Pacing timer: pulses tick once per period cycles while run is high.
 Assumes period is at least 1 and stable while running.
*/
`timescale 1ns/1ps
module asq_pacer
   import asq_pkg::*;
(
   // Clock and control
   input  wire logic clk_sys,
   input  wire logic sys_rst,
   input  wire logic clk_en,
   // Sequencer side
   asq_conv_if.pacer pc
);
   logic [23:0] cnt_r;

   // ===================================================================
   // Free count restarted whenever the scan is idle; the restart waits on
   // clk_en too, so a frozen block keeps its count
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         cnt_r <= 24'h00_0000;
      end else if (clk_en) begin
         if (!pc.run) begin
            cnt_r <= 24'h00_0000;
         end else if (cnt_r + 24'h00_0001 >= pc.period) begin
            cnt_r <= 24'h00_0000;
         end else begin
            cnt_r <= cnt_r + 24'h00_0001;
         end
      end
   end

   // Tick on the wrap, so ticks are evenly spaced
   assign pc.tick = clk_en && pc.run && (cnt_r + 24'h00_0001 >= pc.period);

endmodule : asq_pacer

// file: rtl/asq_scan_ctrl.sv
/*
 Acquisition controller: single conversions, paced scans and bursts.
 Assumes the converter answers conv_done with conv_data some cycles after
 conv_start, and that host command pulses are on clk_sys. The trigger pin
 is asynchronous and is synchronised here.
*/
`timescale 1ns/1ps
module asq_scan_ctrl
   import asq_pkg::*;
#(
   parameter int unsigned DATA_W = ASQ_DATA_W,
   parameter int unsigned DEPTH  = ASQ_BURST_DEPTH
) (
   // Clock, reset, enable
   input  wire logic              clk_sys,
   input  wire logic              sys_rst,
   input  wire logic              clk_en,
   // Host command side
   input  wire logic [1:0]        mode,
   input  wire logic              link_usb,
   input  wire logic              cmd_start,
   input  wire logic              cmd_stop,
   input  wire logic              trig_en,
   input  wire logic [2:0]        ch_last,
   input  wire logic [13:0]       burst_len,
   input  wire logic [23:0]       rate_div,
   // External trigger pin
   input  wire logic              trig_pin,
   // Converter
   output logic                   conv_start,
   output logic [2:0]             conv_ch,
   input  wire logic              conv_done,
   input  wire logic [DATA_W-1:0] conv_data,
   // Sample stream to host
   output logic                   smp_valid,
   output logic [DATA_W-1:0]      smp_data,
   output logic [2:0]             smp_ch,
   output logic                   smp_blk_end,
   input  wire logic              smp_ready,
   // Status
   output logic                   busy,
   output logic                   burst_err
);
   asq_conv_if pc ();
   asq_state_t   state_r;
   logic [2:0]   ch_r;
   logic         trig_s1_r, trig_s2_r, trig_d_r;
   logic         trig_evt;
   logic [4:0]   blk_r;
   logic [13:0]  wr_r, rd_r, bl_r;
   logic         pend_r;
   logic [DATA_W+2:0] mem [0:DEPTH-1];
   logic [2:0]   cur_ch_r;
   logic [23:0]  min_per, per;
   logic         go;

   asq_pacer u_pacer (
      .clk_sys (clk_sys),
      .sys_rst (sys_rst),
      .clk_en  (clk_en),
      .pc      (pc)
   );

   // ===================================================================
   // Trigger synchroniser and rising edge
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         trig_s1_r <= 1'b0;
         trig_s2_r <= 1'b0;
         trig_d_r  <= 1'b0;
      end else if (clk_en) begin
         trig_s1_r <= trig_pin;
         trig_s2_r <= trig_s1_r;
         trig_d_r  <= trig_s2_r;
      end
   end
   assign trig_evt = trig_s2_r && !trig_d_r;

   // Start by command, or by trigger when armed
   assign go = cmd_start || (trig_en && trig_evt);

   // ===================================================================
   // Pacing period: the aggregate rate floor depends on link and mode.
   // Bursts pace at the fast rate whatever the link
   always_comb begin
      if (mode == ASQ_MODE_BURST || link_usb) begin
         min_per = 24'(ASQ_USB_CYC);
      end else begin
         min_per = 24'(ASQ_WIRE_CYC);
      end
      per = (rate_div < min_per) ? min_per : rate_div;
   end
   assign pc.period = per;
   assign pc.run    = (state_r == ASQ_SCAN) || (state_r == ASQ_BACQ);

   // ===================================================================
   // Main sequencer
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         state_r <= ASQ_IDLE;
      end else if (clk_en) begin
         case (state_r)
            ASQ_IDLE: begin
               if (go && mode == ASQ_MODE_SINGLE) begin
                  state_r <= ASQ_SCONV;
               end else if (go && mode == ASQ_MODE_PACED) begin
                  state_r <= ASQ_SCAN;
               end else if (go && mode == ASQ_MODE_BURST &&
                            {18'h0_0000, burst_len} <= DEPTH && burst_len != 14'h0000) begin
                  state_r <= ASQ_BACQ;
               end
            end
            ASQ_SCONV: if (conv_done) begin
               state_r <= ASQ_SRET;
            end
            // Hold until the host takes the value
            ASQ_SRET: if (smp_ready) begin
               state_r <= ASQ_IDLE;
            end
            // Runs until stopped
            ASQ_SCAN: if (cmd_stop) begin
               state_r <= ASQ_IDLE;
            end
            ASQ_BACQ: begin
               if (cmd_stop || (conv_done && wr_r + 14'h0001 == bl_r)) begin
                  state_r <= ASQ_BXFER;
               end
            end
            // Busy stays high until drained, which the host must wait on
            ASQ_BXFER: if (rd_r == wr_r && !pend_r) begin
               state_r <= ASQ_IDLE;
            end
            default: state_r <= ASQ_IDLE;
         endcase
      end
   end

   // ===================================================================
   // Channel walker: round robin over 0..ch_last
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         ch_r <= 3'h0;
      end else if (clk_en) begin
         if (state_r == ASQ_IDLE) begin
            ch_r <= 3'h0;
         end else if (pc.tick) begin
            ch_r <= (ch_r == ch_last) ? 3'h0 : ch_r + 3'h1;
         end
      end
   end

   // Converter kick: one per single-mode command or per pacing tick
   assign conv_start = clk_en && ((state_r == ASQ_IDLE && go && mode == ASQ_MODE_SINGLE)
                                  || pc.tick);
   assign conv_ch    = (state_r == ASQ_IDLE) ? 3'h0 : ch_r;

   // Channel of the conversion in flight; ch_r has moved on by the answer
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         cur_ch_r <= 3'h0;
      end else if (conv_start) begin
         cur_ch_r <= conv_ch;
      end
   end

   // ===================================================================
   // Burst error: request over memory depth is refused and flagged
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         burst_err <= 1'b0;
      end else if (clk_en) begin
         if (state_r == ASQ_IDLE && go && mode == ASQ_MODE_BURST) begin
            burst_err <= ({18'h0_0000, burst_len} > DEPTH);
         end
      end
   end

   // ===================================================================
   // Burst memory: written during acquisition, read out afterwards
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         wr_r   <= 14'h0000;
         rd_r   <= 14'h0000;
         bl_r   <= 14'h0000;
         pend_r <= 1'b0;
      end else if (clk_en) begin
         if (state_r == ASQ_IDLE) begin
            wr_r   <= 14'h0000;
            rd_r   <= 14'h0000;
            bl_r   <= burst_len;
            pend_r <= 1'b0;
         end else if (state_r == ASQ_BACQ && conv_done) begin
            wr_r <= wr_r + 14'h0001;
         end else if (state_r == ASQ_BXFER) begin
            // One word prefetched into the output register; it waits for the host
            if (!pend_r && rd_r != wr_r) begin
               rd_r   <= rd_r + 14'h0001;
               pend_r <= 1'b1;
            end else if (pend_r && smp_ready) begin
               pend_r <= 1'b0;
            end
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (clk_en && state_r == ASQ_BACQ && conv_done) begin
         mem[wr_r] <= {cur_ch_r, conv_data};
      end
   end

   // ===================================================================
   // Output data register for single, paced and buffered burst samples
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         smp_data <= '0;
         smp_ch   <= 3'h0;
      end else if (clk_en) begin
         if (conv_done && (state_r == ASQ_SCONV || state_r == ASQ_SCAN)) begin
            smp_data <= conv_data;
            smp_ch   <= cur_ch_r;
         end else if (state_r == ASQ_BXFER && !pend_r && rd_r != wr_r) begin
            {smp_ch, smp_data} <= mem[rd_r];
         end
      end
   end

   // Paced valid: one pulse per fresh conversion
   logic scan_v_r;
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         scan_v_r <= 1'b0;
      end else if (clk_en) begin
         scan_v_r <= conv_done && state_r == ASQ_SCAN;
      end
   end

   // Block counter for USB paced scans
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         blk_r <= 5'h00;
      end else if (clk_en) begin
         if (state_r == ASQ_IDLE) begin
            blk_r <= 5'h00;
         end else if (scan_v_r) begin
            blk_r <= blk_r + 5'h01;
         end
      end
   end

   // The stream consumer is assumed always ready in paced scans; the
   // pacing floor keeps the rate within what the link carries.
   assign smp_valid   = (state_r == ASQ_SRET) || scan_v_r ||
                        (state_r == ASQ_BXFER && pend_r);
   assign smp_blk_end = scan_v_r && link_usb &&
                        (blk_r == 5'(ASQ_BLOCK_LEN - 1));
   assign busy        = (state_r != ASQ_IDLE);

   // ===================================================================
   // Checks
   property p_single_once;
      @(posedge clk_sys) disable iff (sys_rst)
      (state_r == ASQ_SRET) |-> !conv_start;
   endproperty
   a_single_once: assert property (p_single_once) else $error("Extra conversion");

   property p_ch_range;
      @(posedge clk_sys) disable iff (sys_rst)
      (state_r == ASQ_SCAN) |-> (ch_r <= ch_last);
   endproperty
   a_ch_range: assert property (p_ch_range) else $error("Channel past list");

   property p_scan_holds;
      @(posedge clk_sys) disable iff (sys_rst)
      (state_r == ASQ_SCAN && !cmd_stop && clk_en) |=> (state_r == ASQ_SCAN);
   endproperty
   a_scan_holds: assert property (p_scan_holds) else $error("Scan ended unasked");

   property p_wire_rate;
      @(posedge clk_sys) disable iff (sys_rst)
      (pc.tick && !link_usb && mode == ASQ_MODE_PACED) |=> !pc.tick [*8];
   endproperty
   a_wire_rate: assert property (p_wire_rate) else $error("Wireless rate high");

   property p_usb_rate;
      @(posedge clk_sys) disable iff (sys_rst)
      pc.tick |-> (pc.period >= 24'(ASQ_USB_CYC));
   endproperty
   a_usb_rate: assert property (p_usb_rate) else $error("Rate floor broken");

   property p_block;
      @(posedge clk_sys) disable iff (sys_rst)
      smp_blk_end |-> (link_usb && scan_v_r && blk_r == 5'h1f);
   endproperty
   a_block: assert property (p_block) else $error("Bad block mark");

   property p_start;
      @(posedge clk_sys) disable iff (sys_rst)
      (state_r == ASQ_IDLE && $changed(state_r) == 1'b0 && clk_en && go &&
       mode == ASQ_MODE_PACED) |=> (state_r == ASQ_SCAN);
   endproperty
   a_start: assert property (p_start) else $error("Scan did not start");

   property p_depth;
      @(posedge clk_sys) disable iff (sys_rst)
      (state_r == ASQ_BACQ) |-> ({18'h0_0000, wr_r} < DEPTH);
   endproperty
   a_depth: assert property (p_depth) else $error("Burst overflow");

   property p_err;
      @(posedge clk_sys) disable iff (sys_rst)
      (state_r == ASQ_IDLE && clk_en && go && mode == ASQ_MODE_BURST &&
       {18'h0_0000, burst_len} > DEPTH) |=> (burst_err && state_r == ASQ_IDLE);
   endproperty
   a_err: assert property (p_err) else $error("Oversize burst not flagged");

endmodule : asq_scan_ctrl

// file: bench/asq_conv_model.sv
/*
 Converter stand-in: answers each conv_start with one conv_done lat+2 cycles later.
 Assumes one conversion at a time; data is {channel, running count}.
*/
`timescale 1ns/1ps
module asq_conv_model (
   // Clock and reset
   input  wire logic        clk_sys,
   input  wire logic        sys_rst,
   // Converter pins
   input  wire logic        conv_start,
   input  wire logic [2:0]  conv_ch,
   input  wire logic [7:0]  lat,
   output logic             conv_done,
   output logic [11:0]      conv_data
);
   logic [8:0] idx_r;
   logic [7:0] cnt_r;
   logic [2:0] ch_r;
   logic       act_r;
   // ===================================================================
   // Timer; between answers the data lines toggle between the last value and its complement
   always_ff @(posedge clk_sys) begin
      conv_done <= 1'b0;
      conv_data <= ~conv_data;
      if (sys_rst) begin
         idx_r     <= '0;
         act_r     <= 1'b0;
         conv_data <= '0;
      end else if (conv_start) begin
         act_r <= 1'b1;
         ch_r  <= conv_ch;
         cnt_r <= lat;
      end else if (act_r && cnt_r == 8'h00) begin
         act_r     <= 1'b0;
         conv_done <= 1'b1;
         conv_data <= {ch_r, idx_r};
         idx_r     <= idx_r + 1'b1;
      end else if (act_r) begin
         cnt_r <= cnt_r - 1'b1;
      end
   end
endmodule : asq_conv_model

// file: bench/asq_scan_ctrl_tb_top.sv
/*
 Testbench for the acquisition controller: single, paced and burst runs.
 Assumes the converter stand-in in asq_conv_model and a 10 MHz clock.
*/
`timescale 1ns/1ps
module asq_scan_ctrl_tb_top;
   import asq_pkg::*;
   typedef struct {logic [11:0] data; logic [2:0] ch; logic blk;} asq_exp_t;
   logic clk_sys, sys_rst, cmd_start, cmd_stop, trig_en, trig_pin, link_usb;
   logic conv_start, conv_done, smp_valid, smp_blk_end, smp_ready, busy, burst_err;
   logic [1:0]  mode;
   logic [2:0]  ch_last, conv_ch, smp_ch, rr;
   logic [13:0] burst_len;
   logic [23:0] rate_div, per_exp;
   logic [11:0] conv_data, smp_data;
   logic [7:0]  lat;
   logic        gap_on;
   int          n_mismatch, compares, n_conv, gap, cyc, seed, k;
   asq_exp_t    exp_q[$];
   asq_exp_t    e, m, g;

   asq_scan_ctrl dut_u (.clk_sys(clk_sys), .sys_rst(sys_rst), .clk_en(1'b1), .mode(mode),
      .link_usb(link_usb), .cmd_start(cmd_start), .cmd_stop(cmd_stop), .trig_en(trig_en),
      .ch_last(ch_last), .burst_len(burst_len), .rate_div(rate_div), .trig_pin(trig_pin),
      .conv_start(conv_start), .conv_ch(conv_ch), .conv_done(conv_done),
      .conv_data(conv_data), .smp_valid(smp_valid), .smp_data(smp_data), .smp_ch(smp_ch),
      .smp_blk_end(smp_blk_end), .smp_ready(smp_ready), .busy(busy), .burst_err(burst_err));
   asq_conv_model conv_u (.clk_sys(clk_sys), .sys_rst(sys_rst), .conv_start(conv_start),
      .conv_ch(conv_ch), .lat(lat), .conv_done(conv_done), .conv_data(conv_data));

   // ===================================================================
   // Checking and closing
   task automatic cmp_val(string nm, logic [23:0] ex, logic [23:0] got);
      compares++;
      if (got !== ex) begin
         n_mismatch++;
         $display("BAD %s expected %0h seen %0h", nm, ex, got);
      end
   endtask : cmp_val
   task automatic cmp_bit(string nm, logic ex, logic got);
      cmp_val(nm, {23'h0, ex}, {23'h0, got});
   endtask : cmp_bit
   task automatic finish_test();
      $display("compares %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : finish_test

   // ===================================================================
   // Clock and hang guard
   initial begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 60000) begin
         n_mismatch++;
         finish_test();
      end
   end

   // Note each conversion's expected sample; spacing is checked here as well
   always @(posedge clk_sys) begin
      if (!sys_rst && conv_start === 1'b1) begin
         e.ch   = (mode == ASQ_MODE_SINGLE) ? conv_ch : rr;
         e.data = {e.ch, m.data[8:0]};
         e.blk  = link_usb && mode == ASQ_MODE_PACED && (n_conv % 32 == 31);
         exp_q.push_back(e);
         if (gap_on && mode != ASQ_MODE_SINGLE) cmp_val("spacing", per_exp, gap[23:0]);
         m.data = m.data + 1'b1;
         rr     = (rr == ch_last) ? 3'h0 : rr + 1'b1;
         n_conv++;
         gap    = 1;
         gap_on = 1'b1;
      end else begin
         gap++;
      end
   end

   // Take the oldest note whenever the host accepts a sample
   always @(posedge clk_sys) begin
      if (!sys_rst && smp_valid === 1'b1 && smp_ready === 1'b1) begin
         if (exp_q.size() == 0) begin
            cmp_bit("unexpected sample", 1'b0, 1'b1);
         end else begin
            g = exp_q.pop_front();
            cmp_val("sample data", {12'h0, g.data}, {12'h0, smp_data});
            cmp_val("sample channel", {21'h0, g.ch}, {21'h0, smp_ch});
            cmp_bit("block end", g.blk, smp_blk_end);
         end
      end
   end

   // ===================================================================
   // Stimulus helpers
   task automatic go(logic use_trig);
      @(posedge clk_sys);
      if (use_trig) trig_pin <= 1'b1;
      else cmd_start <= 1'b1;
      rr     <= 3'h0;
      n_conv <= 0;
      gap_on <= 1'b0;
      @(posedge clk_sys);
      cmd_start <= 1'b0;
   endtask : go
   task automatic wait_conv(int want, int lim);
      for (k = 0; k < lim && n_conv < want; k++) @(posedge clk_sys);
      cmp_bit("conversions reached", 1'b1, n_conv >= want);
   endtask : wait_conv
   task automatic stop_idle();
      @(posedge clk_sys);
      cmd_stop <= 1'b1;
      @(posedge clk_sys);
      cmd_stop <= 1'b0;
      for (k = 0; k < 100 && busy !== 1'b0; k++) @(posedge clk_sys);
      k = n_conv;
      repeat (400) @(posedge clk_sys);
      cmp_val("conversions after stop", k[23:0], n_conv[23:0]);
      // A conversion in flight at the stop is answered after the scan ends
      cmp_bit("notes left after stop", 1'b1, exp_q.size() <= 1);
      exp_q.delete();
   endtask : stop_idle

   // ===================================================================
   // Main sequence
   initial begin
      {sys_rst, smp_ready} = 2'b11;
      {cmd_start, cmd_stop, trig_en, trig_pin, link_usb, gap_on} = '0;
      {mode, ch_last, burst_len, rate_div, per_exp, lat} = '0;
      seed = 69718;
      m.data = '0;
      repeat (4) @(posedge clk_sys);
      sys_rst <= 1'b0;
      // Single conversions: one result per command, held until taken
      for (int i = 0; i < 2; i++) begin
         mode      <= ASQ_MODE_SINGLE;
         smp_ready <= 1'b0;
         lat       <= 8'($random(seed) & 7);
         go(1'b0);
         // A second start while busy must be ignored
         @(posedge clk_sys);
         cmd_start <= 1'b1;
         @(posedge clk_sys);
         cmd_start <= 1'b0;
         repeat (20) @(posedge clk_sys);
         cmp_bit("single value stands", 1'b1, smp_valid);
         cmp_val("single conversions", 24'h1, n_conv[23:0]);
         smp_ready <= 1'b1;
         for (k = 0; k < 20 && busy !== 1'b0; k++) @(posedge clk_sys);
      end
      $display("test single done");
      // USB paced scan, three channels, rate clamped to the USB limit
      mode     <= ASQ_MODE_PACED;
      link_usb <= 1'b1;
      ch_last  <= 3'h2;
      rate_div <= 24'h1 + 24'($random(seed) & 127);
      per_exp  <= 24'(ASQ_USB_CYC);
      go(1'b0);
      wait_conv(40, 40 * 220);
      stop_idle();
      $display("test usb scan done");
      // Wireless scan of eight channels, started by the trigger pin
      link_usb <= 1'b0;
      ch_last  <= 3'h7;
      rate_div <= 24'h0000_0064;
      per_exp  <= 24'(ASQ_WIRE_CYC);
      trig_en  <= 1'b1;
      go(1'b1);
      repeat (4) @(posedge clk_sys);
      cmp_bit("trigger start", 1'b1, busy);
      wait_conv(1, 9800);
      wait_conv(3, 2 * 9800);
      trig_pin <= 1'b0;
      trig_en  <= 1'b0;
      stop_idle();
      $display("test wireless scan done");
      // Burst too long is refused with an error
      mode      <= ASQ_MODE_BURST;
      burst_len <= 14'h3001;
      rate_div  <= 24'h1;
      per_exp   <= 24'(ASQ_USB_CYC);
      smp_ready <= 1'b0;
      go(1'b0);
      repeat (5) @(posedge clk_sys);
      cmp_bit("burst error", 1'b1, burst_err);
      cmp_bit("busy after refusal", 1'b0, busy);
      cmp_val("refused conversions", 24'h0, n_conv[23:0]);
      // Short burst at full rate on the wireless link, held while stalled, then drained
      burst_len <= 14'h0005;
      go(1'b0);
      repeat (3) @(posedge clk_sys);
      cmp_bit("burst error cleared", 1'b0, burst_err);
      wait_conv(5, 5 * 220);
      repeat (20) @(posedge clk_sys);
      cmp_bit("busy until drained", 1'b1, busy);
      smp_ready <= 1'b1;
      for (k = 0; k < 200 && busy !== 1'b0; k++) @(posedge clk_sys);
      cmp_val("words left", 24'h0, 24'(exp_q.size()));
      $display("test burst done");
      finish_test();
   end
endmodule : asq_scan_ctrl_tb_top
